// ===== inc/fic_pkg.sv
// Purpose: Shared constants for the frame intake control block.
// Assumes: One 125 MHz clock; command fields arrive already decoded to bytes.
// Notes:   Command codes and status bit positions are named once here.

// ----------------------------------------------------------------------------
// Package
// ----------------------------------------------------------------------------
package fic_pkg;

	localparam int DATA_W = 32;
	localparam int FIFO_DEPTH = 8;
	localparam int CNT_W = 16;

	// Engine states as they appear in the status field.
	typedef enum logic [3:0] {
		FIC_IDLE  = 4'b0000,
		FIC_SUSP  = 4'b0001,
		FIC_NORES = 4'b0010,
		FIC_READY = 4'b0100
	} fic_state_t;

	// Receive control field of the command byte.
	localparam logic [2:0] CMD_NONE   = 3'h0;
	localparam logic [2:0] CMD_START  = 3'h1;
	localparam logic [2:0] CMD_RESUME = 3'h2;
	localparam logic [2:0] CMD_ABORT  = 3'h4;
	localparam logic [2:0] CMD_LDHDS  = 3'h5;

	// Status word layout.
	localparam int STAT_STATE_LSB = 2;
	localparam int STAT_STATE_MSB = 5;
	localparam int STAT_RNR_BIT = 12;
	localparam int STAT_CMD_BIT = 13;
	localparam int STAT_FR_BIT = 14;
	localparam logic [15:0] STAT_RESET = 16'h0000;
	localparam logic [7:0] ACK_NONE = 8'h00;

endpackage : fic_pkg

// ===== inc/fic_evt_if.sv
// Purpose: Event carrier from the intake engine to the status keeper.
// Assumes: Every event signal is a one-cycle pulse except the state.
// Notes:   The engine drives, the status keeper listens.

`timescale 1ns/1ps

interface fic_evt_if;
	logic                 accept;
	logic                 state_chg;
	logic                 frame_done;
	logic                 rnr_req;
	logic                 cmd_irq_done;
	fic_pkg::fic_state_t  state;

	modport src (output accept, state_chg, frame_done, rnr_req, cmd_irq_done, state);
	modport dst (input accept, state_chg, frame_done, rnr_req, cmd_irq_done, state);
endinterface : fic_evt_if

// ===== rtl/fic_fifo.sv
// Purpose: Frame data buffer between the link intake and descriptor DMA.
// Assumes: Synchronous single clock; width and depth set by parameters.
// Notes:   Depth must be a power of two.

`timescale 1ns/1ps

module fic_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input  wire logic             clock_i,
	input  wire logic             rst_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	// Full and empty come straight from the occupancy count.
	assign in_ready_o  = (count != (AW+1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;
	assign out_data_o  = mem[rd_ptr];

	// Storage has no reset; only pointers and count need a defined value.
	always_ff @(posedge clock_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	// Pointers and count.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + AW'(1);
			end
			if (pop) begin
				rd_ptr <= rd_ptr + AW'(1);
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : fic_fifo

// ===== rtl/fic_status.sv
// Purpose: Keeps the status word and the pending interrupt bits.
// Assumes: Acknowledge byte writes arrive as a one-cycle strobe.
// Notes:   The word is refreshed only on the listed events and on acknowledge writes, never free running.

`timescale 1ns/1ps

module fic_status (
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	fic_evt_if.dst           evt,
	input  wire logic        ack_we_i,
	input  wire logic [7:0]  ack_i,
	output logic      [15:0] status_word_o,
	output logic             status_write_o,
	output logic             interrupt_line_o
);
	logic fr_pend;
	logic rnr_pend;
	logic cmd_pend;
	logic next_fr_pend;
	logic next_rnr_pend;
	logic next_cmd_pend;
	logic refresh;

	assign refresh = evt.accept | evt.state_chg | evt.frame_done | evt.cmd_irq_done;

	assign next_fr_pend  = evt.frame_done | (fr_pend & ~(ack_we_i & ack_i[fic_pkg::STAT_FR_BIT-8]));
	assign next_rnr_pend = evt.rnr_req | (rnr_pend & ~(ack_we_i & ack_i[fic_pkg::STAT_RNR_BIT-8]));
	assign next_cmd_pend = evt.cmd_irq_done
		| (cmd_pend & ~(ack_we_i & ack_i[fic_pkg::STAT_CMD_BIT-8]));

	// Pending interrupt bits.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			fr_pend  <= 1'b0;
			rnr_pend <= 1'b0;
			cmd_pend <= 1'b0;
		end else begin
			fr_pend  <= next_fr_pend;
			rnr_pend <= next_rnr_pend;
			cmd_pend <= next_cmd_pend;
		end
	end

	assign interrupt_line_o = fr_pend | rnr_pend | cmd_pend;

	// status written a cycle after the command byte clear.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			status_word_o  <= fic_pkg::STAT_RESET;
			status_write_o <= 1'b0;
		end else begin
			status_write_o <= refresh;
			if (refresh) begin
				status_word_o[fic_pkg::STAT_STATE_MSB:fic_pkg::STAT_STATE_LSB] <= evt.state;
			end
			// Bits track the pending flags, so an acknowledge met by a refresh still clears.
			if (refresh || ack_we_i) begin
				status_word_o[fic_pkg::STAT_FR_BIT]  <= next_fr_pend;
				status_word_o[fic_pkg::STAT_RNR_BIT] <= next_rnr_pend;
				status_word_o[fic_pkg::STAT_CMD_BIT] <= next_cmd_pend;
			end
		end
	end
endmodule : fic_status

// ===== rtl/fic_intake.sv
// Purpose: Control state machine of the frame intake engine.
// Assumes: Command unit presents the receive command only after its own acceptance.
// Notes:   Descriptor DMA datapath lives outside; this block steers and reports it.

`timescale 1ns/1ps

module fic_intake (
	input  wire logic                       clock_i,
	input  wire logic                       rst_i,
	// Command hand-over from the command unit.
	input  wire logic                       cmd_valid_i,
	input  wire logic [2:0]                 cmd_code_i,
	input  wire logic [31:0]                rfa_offset_i,
	output logic                            cmd_clear_o,
	input  wire logic                       cu_irq_done_i,
	// Frame arrival from the link side.
	input  wire logic                       frame_active_i,
	input  wire logic                       frame_end_i,
	input  wire logic                       rx_valid_i,
	input  wire logic [fic_pkg::DATA_W-1:0] rx_data_i,
	output logic                            rx_ready_o,
	// Descriptor DMA side.
	output logic                            dma_valid_o,
	output logic      [fic_pkg::DATA_W-1:0] dma_data_o,
	input  wire logic                       dma_ready_i,
	input  wire logic                       rfd_done_i,
	input  wire logic                       rfd_end_of_list_flag_i,
	input  wire logic                       rfd_suspend_flag_i,
	input  wire logic                       rfd_data_moved_i,
	output logic                            rfd_setup_o,
	output logic                            release_buffers_o,
	output logic                            dma_abort_o,
	output logic      [31:0]                next_rfd_ptr_o,
	output logic      [31:0]                header_size_o,
	// Status and reporting.
	output logic      [3:0]                 ru_state_o,
	output logic                            discarding_o,
	output logic      [fic_pkg::CNT_W-1:0]  discard_count_o,
	output logic                            pending_start_flag_o,
	output logic                            pending_resume_flag_o,
	input  wire logic                       ack_we_i,
	input  wire logic [7:0]                 ack_i,
	output logic      [15:0]                status_word_o,
	output logic                            status_write_o,
	output logic                            interrupt_line_o
);

	// ------------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------------
	fic_pkg::fic_state_t state;
	fic_pkg::fic_state_t prev_state;
	logic                discard_frame;
	logic                accept;
	logic                is_start;
	logic                is_resume;
	logic                is_abort;
	logic                is_ldhds;
	logic                start_go;
	logic                resume_go;
	logic                end_start;
	logic                end_resume;
	logic                discard;
	logic                frame_ok;
	logic                fifo_out_valid;
	logic                fifo_out_ready;

	fic_evt_if evt ();

	// ------------------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------------------
	// accept only on hand-over
	assign accept    = cmd_valid_i;
	assign is_start  = accept & (cmd_code_i == fic_pkg::CMD_START);
	assign is_resume = accept & (cmd_code_i == fic_pkg::CMD_RESUME);
	assign is_abort  = accept & (cmd_code_i == fic_pkg::CMD_ABORT);
	assign is_ldhds  = accept & (cmd_code_i == fic_pkg::CMD_LDHDS);

	assign start_go = is_start & ~frame_active_i & (state != fic_pkg::FIC_READY)
		& ~rfd_data_moved_i;

	assign resume_go = is_resume & (state == fic_pkg::FIC_SUSP)
		& ~(frame_active_i | discard_frame);

	// pending start taken at frame end
	assign end_start = frame_end_i & pending_start_flag_o & ~is_abort;

	// pending resume taken at frame end
	assign end_resume = frame_end_i & (pending_resume_flag_o | is_resume) & ~is_abort
		& (state == fic_pkg::FIC_SUSP);

	// A frame is dropped whenever the engine cannot store it.
	assign discard  = (state != fic_pkg::FIC_READY) | discard_frame;
	assign frame_ok = frame_end_i & ~discard;

	// ------------------------------------------------------------------------
	// Engine state
	// ------------------------------------------------------------------------
	// Abort outranks everything so a late descriptor event cannot reopen intake.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state <= fic_pkg::FIC_IDLE;
		end else if (is_abort) begin
			state <= fic_pkg::FIC_IDLE;
		end else if (start_go | resume_go | end_start | end_resume) begin
			state <= fic_pkg::FIC_READY;
		end else if (rfd_done_i && state == fic_pkg::FIC_READY) begin
			if (rfd_end_of_list_flag_i) begin
				state <= fic_pkg::FIC_NORES;
			end else if (rfd_suspend_flag_i) begin
				state <= fic_pkg::FIC_SUSP;
			end
		end
	end

	// Previous state for change detection.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			prev_state <= fic_pkg::FIC_IDLE;
		end else begin
			prev_state <= state;
		end
	end

	// ------------------------------------------------------------------------
	// Per-frame discard tracking
	// ------------------------------------------------------------------------
	// The decision is latched while a frame runs, so a start mid-frame cannot
	// begin storing the tail of a frame whose head was already dropped.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			discard_frame <= 1'b0;
		end else if (is_abort) begin
			discard_frame <= frame_active_i & ~frame_end_i;
		end else if (frame_end_i) begin
			discard_frame <= 1'b0;
		end else if (frame_active_i && state != fic_pkg::FIC_READY) begin
			discard_frame <= 1'b1;
		end
	end

	// count dropped frames when out of descriptors
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			discard_count_o <= '0;
		end else if (frame_end_i && discard && state == fic_pkg::FIC_NORES) begin
			discard_count_o <= discard_count_o + fic_pkg::CNT_W'(1);
		end
	end

	// ------------------------------------------------------------------------
	// Pending flags
	// ------------------------------------------------------------------------
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			pending_start_flag_o <= 1'b0;
		end else if (is_abort || end_start) begin
			pending_start_flag_o <= 1'b0;
		end else if (is_start) begin
			// set when receiving, clear when not
			pending_start_flag_o <= frame_active_i;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			pending_resume_flag_o <= 1'b0;
		end else if (is_abort || frame_end_i) begin
			pending_resume_flag_o <= 1'b0;
		end else if (is_resume && state == fic_pkg::FIC_SUSP && !resume_go) begin
			pending_resume_flag_o <= 1'b1;
		end
	end

	// ------------------------------------------------------------------------
	// Pointers loaded at acceptance
	// ------------------------------------------------------------------------
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			next_rfd_ptr_o <= 32'h0000_0000;
		end else if (is_start) begin
			next_rfd_ptr_o <= rfa_offset_i;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			header_size_o <= 32'h0000_0000;
		end else if (is_ldhds) begin
			header_size_o <= rfa_offset_i;
		end
	end

	// ------------------------------------------------------------------------
	// Action pulses
	// ------------------------------------------------------------------------
	// All pulses are registered, one cycle after the causing event.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			cmd_clear_o       <= 1'b0;
			rfd_setup_o       <= 1'b0;
			release_buffers_o <= 1'b0;
			dma_abort_o       <= 1'b0;
		end else begin
			cmd_clear_o       <= accept;
			rfd_setup_o       <= ~is_abort & (start_go | resume_go | end_start | end_resume);
			release_buffers_o <= start_go;
			dma_abort_o       <= is_abort;
		end
	end

	assign ru_state_o   = state;
	assign discarding_o = discard;

	// ------------------------------------------------------------------------
	// Data path
	// ------------------------------------------------------------------------
	// Dropped data is drained at full rate so a stalled DMA cannot hold the link.
	assign fifo_out_ready = discard | dma_ready_i;
	assign dma_valid_o    = fifo_out_valid & ~discard;

	fic_fifo #(
		.WIDTH (fic_pkg::DATA_W),
		.DEPTH (fic_pkg::FIFO_DEPTH)
	) u_fifo (
		.clock_i     (clock_i),
		.rst_i       (rst_i),
		.in_valid_i  (rx_valid_i),
		.in_ready_o  (rx_ready_o),
		.in_data_i   (rx_data_i),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (fifo_out_ready),
		.out_data_o  (dma_data_o)
	);

	// ------------------------------------------------------------------------
	// Events to the status keeper
	// ------------------------------------------------------------------------
	assign evt.accept       = cmd_clear_o;
	assign evt.state_chg    = (state != prev_state);
	assign evt.cmd_irq_done = cu_irq_done_i;
	assign evt.state        = state;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			evt.frame_done <= 1'b0;
			evt.rnr_req    <= 1'b0;
		end else begin
			evt.frame_done <= frame_ok;
			evt.rnr_req    <= is_abort & (state == fic_pkg::FIC_READY);
		end
	end

	fic_status u_status (
		.clock_i          (clock_i),
		.rst_i            (rst_i),
		.evt              (evt.dst),
		.ack_we_i         (ack_we_i),
		.ack_i            (ack_i),
		.status_word_o    (status_word_o),
		.status_write_o   (status_write_o),
		.interrupt_line_o (interrupt_line_o)
	);

endmodule : fic_intake

// ===== testbench/fic_intake_properties.sv
// Purpose: Port-level checks on the frame intake control block.
// Assumes: One clock; reset asynchronous and active high.
// Notes:   Bound to the top module from the bench top file.

`timescale 1ns/1ps

// --------------------------------------------------------------------
// Checker
// --------------------------------------------------------------------
module fic_intake_properties (
	input wire logic        clock_i,
	input wire logic        rst_i,
	input wire logic        cmd_valid_i,
	input wire logic [2:0]  cmd_code_i,
	input wire logic [31:0] rfa_offset_i,
	input wire logic        cmd_clear_o,
	input wire logic        frame_active_i,
	input wire logic        frame_end_i,
	input wire logic        rfd_done_i,
	input wire logic        rfd_end_of_list_flag_i,
	input wire logic        rfd_data_moved_i,
	input wire logic        rfd_setup_o,
	input wire logic        release_buffers_o,
	input wire logic        dma_abort_o,
	input wire logic [31:0] next_rfd_ptr_o,
	input wire logic [3:0]  ru_state_o,
	input wire logic        pending_start_flag_o,
	input wire logic        pending_resume_flag_o,
	input wire logic [15:0] status_word_o,
	input wire logic        status_write_o,
	input wire logic        interrupt_line_o
);
	default clocking dc @(posedge clock_i);
	endclocking
	default disable iff (rst_i);

	// One command handed over; state terms are chained with ##0.
	sequence s_cmd(c);
		cmd_valid_i && cmd_code_i == c;
	endsequence
	// Frame boundaries and descriptor ends would move the state on their own.
	sequence s_calm;
		!frame_end_i && !rfd_done_i;
	endsequence

	property p_reset_idle;
		$fell(rst_i) |-> ru_state_o == fic_pkg::FIC_IDLE && status_word_o == fic_pkg::STAT_RESET;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("engine not idle after reset");
	property p_accept;
		cmd_valid_i |=> cmd_clear_o ##1 status_write_o;
	endproperty
	a_accept: assert property (p_accept) else $error("command not cleared or status not written");
	property p_start_quiet;
		s_cmd(fic_pkg::CMD_START) ##0 s_calm ##0 (!frame_active_i && !rfd_data_moved_i
			&& ru_state_o != fic_pkg::FIC_READY) |=> ru_state_o == fic_pkg::FIC_READY
			&& rfd_setup_o && release_buffers_o && next_rfd_ptr_o == $past(rfa_offset_i);
	endproperty
	a_start_quiet: assert property (p_start_quiet) else $error("quiet start did not arm");
	property p_start_busy;
		s_cmd(fic_pkg::CMD_START) ##0 s_calm ##0 (frame_active_i
			&& ru_state_o != fic_pkg::FIC_READY) |=> pending_start_flag_o
			&& $stable(ru_state_o) && next_rfd_ptr_o == $past(rfa_offset_i);
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("busy start not deferred");
	property p_resume_ignore;
		s_cmd(fic_pkg::CMD_RESUME) ##0 s_calm ##0 (ru_state_o != fic_pkg::FIC_SUSP) |=> $stable(ru_state_o);
	endproperty
	a_resume_ignore: assert property (p_resume_ignore) else $error("stray resume moved state");
	property p_resume_pend;
		s_cmd(fic_pkg::CMD_RESUME) ##0 s_calm ##0 (frame_active_i && ru_state_o == fic_pkg::FIC_SUSP)
			|=> pending_resume_flag_o && ru_state_o == fic_pkg::FIC_SUSP;
	endproperty
	a_resume_pend: assert property (p_resume_pend) else $error("resume while discarding not held");
	property p_el_nores;
		rfd_done_i && rfd_end_of_list_flag_i && !cmd_valid_i && ru_state_o == fic_pkg::FIC_READY
			|=> ru_state_o == fic_pkg::FIC_NORES;
	endproperty
	a_el_nores: assert property (p_el_nores) else $error("last descriptor did not stop engine");
	property p_abort_idle;
		s_cmd(fic_pkg::CMD_ABORT) |=> ru_state_o == fic_pkg::FIC_IDLE && dma_abort_o;
	endproperty
	a_abort_idle: assert property (p_abort_idle) else $error("abort did not halt engine");
	property p_abort_rnr;
		s_cmd(fic_pkg::CMD_ABORT) ##0 (ru_state_o == fic_pkg::FIC_READY)
			|-> ##[1:3] (interrupt_line_o && status_word_o[fic_pkg::STAT_RNR_BIT]);
	endproperty
	a_abort_rnr: assert property (p_abort_rnr) else $error("abort in ready gave no event");
	property p_state_report;
		$changed(ru_state_o) |=> status_write_o && status_word_o[5:2] == $past(ru_state_o);
	endproperty
	a_state_report: assert property (p_state_report) else $error("state not reported");
endmodule : fic_intake_properties

// ===== testbench/fic_dma_model.sv
// Purpose: Descriptor memory side that sinks the words moved by the intake DMA.
// Assumes: Words are taken on edges where valid and ready meet.
// Notes:   Slow mode draws ready from a shift register, so stalls land at odd spots.

`timescale 1ns/1ps

// --------------------------------------------------------------------
// Memory sink model
// --------------------------------------------------------------------
module fic_dma_model (
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	input  wire logic        stall_i,
	input  wire logic        slow_i,
	input  wire logic        dma_valid_i,
	input  wire logic [31:0] dma_data_i,
	output logic             dma_ready_o
);
	logic [7:0]  lfsr;
	logic [31:0] got[$];

	// Stall pattern generator; restarts from reset so runs repeat.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i)
			lfsr <= 8'h5a;
		else
			lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
	end

	// Held off while stalled, so the buffer in front has to fill and refuse.
	assign dma_ready_o = !stall_i && (!slow_i || lfsr[0]);

	// Every accepted word is logged in arrival order.
	always @(posedge clock_i) begin
		if (!rst_i && dma_valid_i && dma_ready_o)
			got.push_back(dma_data_i);
	end
endmodule : fic_dma_model

// ===== testbench/tb.sv
// Purpose: Self-checking bench for the frame intake control block.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Fixed seed; frame words are random, command cases hand-picked.

`timescale 1ns/1ps

// --------------------------------------------------------------------
// Bench top
// --------------------------------------------------------------------
module tb;
	logic        clock_i, rst_i, cmd_valid_i, cu_irq_done_i, frame_active_i, frame_end_i;
	logic        rx_valid_i, rfd_done_i, rfd_end_of_list_flag_i, rfd_suspend_flag_i;
	logic        rfd_data_moved_i, ack_we_i, stall, slow, cmd_clear_o, rx_ready_o;
	logic        dma_valid_o, dma_ready_i, rfd_setup_o, release_buffers_o, dma_abort_o;
	logic        discarding_o, pending_start_flag_o, pending_resume_flag_o;
	logic        status_write_o, interrupt_line_o;
	logic [2:0]  cmd_code_i;
	logic [7:0]  ack_i;
	logic [31:0] rfa_offset_i, rx_data_i, dma_data_o, next_rfd_ptr_o, header_size_o, off;
	logic [3:0]  ru_state_o;
	logic [15:0] discard_count_o, status_word_o;
	logic [31:0] exp_q[$];
	integer      seed, error_cnt, n_checks, n;

	fic_intake u_dut (.clock_i, .rst_i, .cmd_valid_i, .cmd_code_i, .rfa_offset_i, .cmd_clear_o,
		.cu_irq_done_i, .frame_active_i, .frame_end_i, .rx_valid_i, .rx_data_i, .rx_ready_o,
		.dma_valid_o, .dma_data_o, .dma_ready_i, .rfd_done_i, .rfd_end_of_list_flag_i,
		.rfd_suspend_flag_i, .rfd_data_moved_i, .rfd_setup_o, .release_buffers_o, .dma_abort_o,
		.next_rfd_ptr_o, .header_size_o, .ru_state_o, .discarding_o, .discard_count_o,
		.pending_start_flag_o, .pending_resume_flag_o, .ack_we_i, .ack_i, .status_word_o,
		.status_write_o, .interrupt_line_o);
	fic_dma_model u_dma (.clock_i, .rst_i, .stall_i(stall), .slow_i(slow),
		.dma_valid_i(dma_valid_o), .dma_data_i(dma_data_o), .dma_ready_o(dma_ready_i));

	// Free-running 125 MHz clock.
	initial begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end

	task automatic tick;
		@(posedge clock_i);
		#1;
	endtask : tick
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic cmd(input logic [2:0] c, input logic [31:0] o);
		{cmd_valid_i, cmd_code_i, rfa_offset_i} = {1'b1, c, o};
		tick;
		cmd_valid_i = 1'b0;
		tick;
	endtask : cmd
	task automatic ack(input logic [7:0] a);
		{ack_we_i, ack_i} = {1'b1, a};
		tick;
		ack_we_i = 1'b0;
		tick;
	endtask : ack
	task automatic receive_frame_descriptor(input logic el, input logic s);
		{rfd_done_i, rfd_end_of_list_flag_i, rfd_suspend_flag_i} = {1'b1, el, s};
		tick;
		{rfd_done_i, rfd_end_of_list_flag_i, rfd_suspend_flag_i} = 3'h0;
		tick;
	endtask : receive_frame_descriptor
	// Holds valid and data until an edge samples ready high; caller drops valid.
	task automatic push(input logic [31:0] d);
		integer k;
		{rx_valid_i, rx_data_i} = {1'b1, d};
		exp_q.push_back(d);
		k = 0;
		while (!rx_ready_o && k < 200) begin
			k++;
			tick;
		end
		if (k == 200)
			chk("rx ready", 32'h1, 32'h0);
		tick;
	endtask : push
	task automatic frame(input integer nw);
		integer k;
		frame_active_i = 1'b1;
		tick;
		for (k = 0; k < nw; k++)
			push($random(seed));
		rx_valid_i = 1'b0;
		for (k = 0; k < 300 && u_dma.got.size() < exp_q.size(); k++)
			tick;
		frame_end_i = 1'b1;
		tick;
		{frame_end_i, frame_active_i} = 2'h0;
		tick;
		tick;
	endtask : frame
	task automatic cmp_words;
		chk("word count", exp_q.size(), u_dma.got.size());
		foreach (exp_q[i])
			if (i < u_dma.got.size())
				chk("dma word", exp_q[i], u_dma.got[i]);
		exp_q.delete();
		u_dma.got.delete();
	endtask : cmp_words
	task automatic print_verdict;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict

	// Main sequence.
	initial begin
		{seed, error_cnt, n_checks} = {32'hfbb1, 32'h0, 32'h0};
		{cmd_valid_i, cu_irq_done_i, frame_active_i, frame_end_i, rx_valid_i, rfd_done_i} = '0;
		{rfd_end_of_list_flag_i, rfd_suspend_flag_i, rfd_data_moved_i, ack_we_i, stall, slow} = '0;
		{cmd_code_i, ack_i, rfa_offset_i, rx_data_i} = '0;
		rst_i = 1'b1;
		repeat (2) @(posedge clock_i);
		#1;
		rst_i = 1'b0;
		chk("state", fic_pkg::FIC_IDLE, ru_state_o);
		chk("discard", 1'b1, discarding_o);
		rfd_data_moved_i = 1'b1;
		off = $random(seed);
		cmd(fic_pkg::CMD_START, off);
		chk("state", fic_pkg::FIC_IDLE, ru_state_o);
		chk("next ptr", off, next_rfd_ptr_o);
		rfd_data_moved_i = 1'b0;
		cmd(fic_pkg::CMD_START, $random(seed));
		chk("status state", fic_pkg::FIC_READY, status_word_o[5:2]);
		stall = 1'b1;
		frame_active_i = 1'b1;
		n = 0;
		while (rx_ready_o && n < 16) begin
			push($random(seed));
			n++;
		end
		rx_valid_i = 1'b0;
		chk("fill depth", fic_pkg::FIFO_DEPTH, n);
		{stall, slow} = 2'b01;
		frame(3);
		cmp_words;
		chk("frame bit", 1'b1, status_word_o[fic_pkg::STAT_FR_BIT]);
		cu_irq_done_i = 1'b1;
		tick;
		cu_irq_done_i = 1'b0;
		tick;
		tick;
		chk("done bit", 1'b1, status_word_o[fic_pkg::STAT_CMD_BIT]);
		ack(8'h60);
		chk("line", 1'b0, interrupt_line_o);
		receive_frame_descriptor(1'b0, 1'b1);
		chk("state", fic_pkg::FIC_SUSP, ru_state_o);
		frame_active_i = 1'b1;
		push($random(seed));
		rx_valid_i = 1'b0;
		chk("dma valid", 1'b0, dma_valid_o);
		exp_q.delete();
		cmd(fic_pkg::CMD_RESUME, 32'h0);
		chk("resume flag", 1'b1, pending_resume_flag_o);
		frame(0);
		chk("state", fic_pkg::FIC_READY, ru_state_o);
		chk("resume flag", 1'b0, pending_resume_flag_o);
		receive_frame_descriptor(1'b0, 1'b1);
		cmd(fic_pkg::CMD_RESUME, 32'h0);
		chk("state", fic_pkg::FIC_READY, ru_state_o);
		receive_frame_descriptor(1'b1, 1'b1);
		chk("state", fic_pkg::FIC_NORES, ru_state_o);
		cmd(fic_pkg::CMD_RESUME, 32'h0);
		chk("state", fic_pkg::FIC_NORES, ru_state_o);
		frame(0);
		frame(0);
		chk("discards", 16'h0002, discard_count_o);
		frame_active_i = 1'b1;
		tick;
		off = $random(seed);
		cmd(fic_pkg::CMD_START, off);
		chk("start flag", 1'b1, pending_start_flag_o);
		chk("state", fic_pkg::FIC_NORES, ru_state_o);
		frame(0);
		chk("state", fic_pkg::FIC_READY, ru_state_o);
		frame_active_i = 1'b1;
		tick;
		cmd(fic_pkg::CMD_ABORT, 32'h0);
		chk("state", fic_pkg::FIC_IDLE, ru_state_o);
		chk("not ready bit", 1'b1, status_word_o[fic_pkg::STAT_RNR_BIT]);
		frame(0);
		ack(8'h10);
		chk("line", 1'b0, interrupt_line_o);
		cmd(fic_pkg::CMD_ABORT, 32'h0);
		chk("line", 1'b0, interrupt_line_o);
		off = $random(seed);
		cmd(fic_pkg::CMD_LDHDS, off);
		chk("header size", off, header_size_o);
		cmd(fic_pkg::CMD_START, $random(seed));
		repeat (12) begin
			slow = 1'($random(seed));
			frame(($random(seed) & 7) + 1);
			cmp_words;
			chk("line", 1'b1, interrupt_line_o);
			ack(8'h40);
		end
		print_verdict;
	end

	// Guards against a hang far beyond the expected run length.
	initial begin
		repeat (20000) @(posedge clock_i);
		error_cnt++;
		print_verdict;
	end
endmodule : tb

bind fic_intake fic_intake_properties u_props (.clock_i, .rst_i, .cmd_valid_i, .cmd_code_i,
	.rfa_offset_i, .cmd_clear_o, .frame_active_i, .frame_end_i, .rfd_done_i,
	.rfd_end_of_list_flag_i, .rfd_data_moved_i, .rfd_setup_o, .release_buffers_o, .dma_abort_o,
	.next_rfd_ptr_o, .ru_state_o, .pending_start_flag_o, .pending_resume_flag_o, .status_word_o,
	.status_write_o, .interrupt_line_o);
